// [design/dgp_top.sv]
// Two 8-bit general ports sharing pins with LCD segment drive
// Operation
// [RULE_01] Each port has an 8-bit read/write data latch, reset to zero.
// [RULE_02] Reading an output bit returns the latched value, not the pin.
// [RULE_03] Reading an input bit returns the sampled pin level.
// [RULE_04] Direction bit one drives latched data out; zero makes an input.
// [RULE_05] Direction and data act only while the pin is general I/O.
// [RULE_06] Direction registers are write-only and read as all ones.
// [RULE_07] Reset clears all direction bits, so every pin starts as input.
// [RULE_08] First port pins 7-4: select 000x is I/O, else segment drive.
// [RULE_09] First port pins 3-0: 000x or 0010 is I/O, else segment drive.
// [RULE_10] First port hi-Z in reset and standby, holds in sleep modes.
// [RULE_11] Second port pins 3-0: select 0000 is I/O, else segment drive.
// [RULE_12] Second port pins 7-4: extended select routes LCD signals out.
// [RULE_13] Register writes reach the pins at the edge ending the write.
`timescale 1ns/1ps
`include "dgp_cfg.svh"

module dgp_top #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] first_pin_in,
  input wire logic [7:0] second_pin_in,
  output dgp_pkg::dgp_drive_t first_pins,
  output dgp_pkg::dgp_drive_t second_pins,
  input wire logic [7:0] lcd_drive_first,
  input wire logic [7:0] lcd_drive_second,
  input wire logic [3:0] lcd_signal
);

  // ********************************
  // Address decode
  // ********************************
  logic hit_d1;
  logic hit_d2;
  logic hit_c1;
  logic hit_c2;
  logic hit_lcd;
  logic hit_mode;

  assign hit_d1 = (addr == ADDR_W'(`DGP_FIRST_DATA_ADDR));
  assign hit_d2 = (addr == ADDR_W'(`DGP_SECOND_DATA_ADDR));
  assign hit_c1 = (addr == ADDR_W'(`DGP_FIRST_DIR_ADDR));
  assign hit_c2 = (addr == ADDR_W'(`DGP_SECOND_DIR_ADDR));
  assign hit_lcd = (addr == ADDR_W'(`DGP_LCD_CTRL_ADDR));
  assign hit_mode = (addr == ADDR_W'(`DGP_MODE_ADDR));

  // ********************************
  // Port registers
  // ********************************
  logic [7:0] latch1_r;
  logic [7:0] dir1_r;
  logic [7:0] latch1_nxt;
  logic [7:0] dir1_nxt;
  logic [7:0] latch2_r;
  logic [7:0] dir2_r;
  logic [7:0] latch2_nxt;
  logic [7:0] dir2_nxt;

  dgp_port_regs #(.WIDTH(8)) u_first (
    .core_clk(core_clk),
    .rst(rst),
    .data_we(wr && hit_d1),
    .dir_we(wr && hit_c1),
    .wdata(wdata),
    .latch_r(latch1_r),
    .dir_r(dir1_r),
    .latch_nxt(latch1_nxt),
    .dir_nxt(dir1_nxt)
  );

  dgp_port_regs #(.WIDTH(8)) u_second (
    .core_clk(core_clk),
    .rst(rst),
    .data_we(wr && hit_d2),
    .dir_we(wr && hit_c2),
    .wdata(wdata),
    .latch_r(latch2_r),
    .dir_r(dir2_r),
    .latch_nxt(latch2_nxt),
    .dir_nxt(dir2_nxt)
  );

  // ********************************
  // Segment control register
  // ********************************
  dgp_pkg::dgp_lcd_ctrl_t lcd_ctrl_r;
  dgp_pkg::dgp_lcd_ctrl_t lcd_ctrl_nxt;

  always_comb begin
    lcd_ctrl_nxt = lcd_ctrl_r;
    if (wr && hit_lcd) begin
      lcd_ctrl_nxt.sel = wdata[`DGP_SEL_MSB:`DGP_SEL_LSB];
      lcd_ctrl_nxt.ext = wdata[`DGP_EXT_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lcd_ctrl_r <= `DGP_LCD_CTRL_RESET;
    end else begin
      lcd_ctrl_r <= lcd_ctrl_nxt;
    end
  end

  // ********************************
  // Operating mode
  // ********************************
  dgp_pkg::dgp_mode_t mode_r;
  dgp_pkg::dgp_mode_t mode_nxt;
  logic hold_nxt;
  logic standby_nxt;

  always_comb begin
    mode_nxt = mode_r;
    if (wr && hit_mode) begin
      case (wdata[`DGP_MODE_MSB:`DGP_MODE_LSB])
        3'h0: mode_nxt = dgp_pkg::DGP_ACTIVE;
        3'h1: mode_nxt = dgp_pkg::DGP_SUBACTIVE;
        3'h3: mode_nxt = dgp_pkg::DGP_SLEEP;
        3'h2: mode_nxt = dgp_pkg::DGP_SUBSLEEP;
        3'h6: mode_nxt = dgp_pkg::DGP_WATCH;
        3'h7: mode_nxt = dgp_pkg::DGP_STANDBY;
        default: mode_nxt = dgp_pkg::DGP_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= dgp_pkg::DGP_ACTIVE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_comb begin
    case (mode_nxt)
      dgp_pkg::DGP_SLEEP,
      dgp_pkg::DGP_SUBSLEEP,
      dgp_pkg::DGP_WATCH: begin
        hold_nxt = 1'b1;
        standby_nxt = 1'b0;
      end
      dgp_pkg::DGP_STANDBY: begin
        hold_nxt = 1'b0;
        standby_nxt = 1'b1;
      end
      default: begin
        hold_nxt = 1'b0;
        standby_nxt = 1'b0;
      end
    endcase
  end

  // ********************************
  // Pin function select
  // ********************************
  dgp_pkg::dgp_drive_t mux1;
  dgp_pkg::dgp_drive_t mux2;

  dgp_pin_mux #(.SECOND(1'b0)) u_mux_first (
    .ctrl(lcd_ctrl_nxt),
    .latch(latch1_nxt),
    .dir(dir1_nxt),
    .lcd_drive_output(lcd_drive_first),
    .lcd_sig(4'h0),
    .drive(mux1)
  );

  dgp_pin_mux #(.SECOND(1'b1)) u_mux_second (
    .ctrl(lcd_ctrl_nxt),
    .latch(latch2_nxt),
    .dir(dir2_nxt),
    .lcd_drive_output(lcd_drive_second),
    .lcd_sig(lcd_signal),
    .drive(mux2)
  );

  // ********************************
  // Pin drive flops
  // ********************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_pins <= '0; // RULE_10
    end else if (hold_nxt) begin
      first_pins <= first_pins; // RULE_10
    end else if (standby_nxt) begin
      first_pins <= '{o: mux1.o, oe: 8'h00}; // RULE_10
    end else begin
      first_pins <= mux1; // RULE_05 RULE_08 RULE_09 RULE_13
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      second_pins <= '0;
    end else if (hold_nxt) begin
      second_pins <= second_pins;
    end else if (standby_nxt) begin
      second_pins <= '{o: mux2.o, oe: 8'h00};
    end else begin
      second_pins <= mux2; // RULE_04 RULE_11 RULE_12 RULE_13
    end
  end

  // ********************************
  // Read data
  // ********************************
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = `DGP_UNMAPPED_READ;
    if (hit_d1) begin
      rdata_nxt = (dir1_r & latch1_r) | (~dir1_r & first_pin_in); // RULE_02 RULE_03
    end else if (hit_d2) begin
      rdata_nxt = (dir2_r & latch2_r) | (~dir2_r & second_pin_in); // RULE_02 RULE_03
    end else if (hit_c1 || hit_c2) begin
      rdata_nxt = `DGP_DIR_READ; // RULE_06
    end else if (hit_lcd) begin
      rdata_nxt = {3'h0, lcd_ctrl_r.ext, lcd_ctrl_r.sel};
    end else if (hit_mode) begin
      rdata_nxt = {5'h00, mode_r};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic run_mode;
  assign run_mode = (mode_nxt == dgp_pkg::DGP_ACTIVE) ||
                    (mode_nxt == dgp_pkg::DGP_SUBACTIVE);

  a_reset_clears_regs: assert property ( // RULE_01
    $past(rst) |-> latch1_r == 8'h00 && latch2_r == 8'h00 &&
    dir1_r == 8'h00 && dir2_r == 8'h00 && first_pins.oe == 8'h00)
    else $error("Registers or pins not cleared by reset");

  a_reset_all_inputs: assert property ( // RULE_07
    $past(rst) && !wr |=> second_pins.oe == 8'h00 &&
    first_pins.oe == 8'h00)
    else $error("A pin drives right after reset");

  a_read_out_bits: assert property ( // RULE_02
    rd && hit_d1 |=> (rdata & $past(dir1_r)) ==
    ($past(latch1_r) & $past(dir1_r)))
    else $error("Output bit read does not return latch");

  a_read_in_bits: assert property ( // RULE_03
    rd && hit_d2 |=> (rdata & ~$past(dir2_r)) ==
    ($past(second_pin_in) & ~$past(dir2_r)))
    else $error("Input bit read does not return pin level");

  a_dir_reads_ones: assert property ( // RULE_06
    rd && (hit_c1 || hit_c2) |=> rdata == 8'hff)
    else $error("Direction read not all ones");

  a_write_drives_pin: assert property ( // RULE_13
    wr && hit_d1 && run_mode && lcd_ctrl_nxt.sel == 4'h0 &&
    dir1_r == 8'hff |=> first_pins.o == $past(wdata) &&
    first_pins.oe == 8'hff)
    else $error("Data write not on pins at the next edge");

  a_dir_sets_oe: assert property ( // RULE_04
    wr && hit_c2 && run_mode && lcd_ctrl_nxt.sel == 4'h0 &&
    !lcd_ctrl_nxt.ext |=> second_pins.oe == $past(wdata))
    else $error("Direction write not reflected in enables");

  a_seg_high_nibble: assert property ( // RULE_08
    run_mode && lcd_ctrl_nxt.sel[3:1] != 3'h0 |=>
    first_pins.oe[7:4] == 4'hf &&
    first_pins.o[7:4] == $past(lcd_drive_first[7:4]))
    else $error("First port high pins not on segment drive");

  a_seg_low_nibble: assert property ( // RULE_09
    run_mode && lcd_ctrl_nxt.sel > 4'h2 |=>
    first_pins.oe[3:0] == 4'hf &&
    first_pins.o[3:0] == $past(lcd_drive_first[3:0]))
    else $error("First port low pins not on segment drive");

  a_gpio_low_nibble: assert property ( // RULE_05
    run_mode && lcd_ctrl_nxt.sel == 4'h2 |=>
    first_pins.oe[3:0] == $past(dir1_nxt[3:0]) &&
    first_pins.oe[7:4] == 4'hf)
    else $error("Select 0010 split decoded wrongly");

  a_standby_hiz: assert property ( // RULE_10
    mode_r == dgp_pkg::DGP_STANDBY |-> first_pins.oe == 8'h00)
    else $error("First port drives in standby");

  a_sleep_holds: assert property ( // RULE_10
    hold_nxt && !$past(rst) |=> $stable(first_pins))
    else $error("First port changed during a hold mode");

  a_second_seg_low: assert property ( // RULE_11
    run_mode && lcd_ctrl_nxt.sel != 4'h0 |=>
    second_pins.oe[3:0] == 4'hf &&
    second_pins.o[3:0] == $past(lcd_drive_second[3:0]))
    else $error("Second port low pins not on segment drive");

  a_ext_routes_signals: assert property ( // RULE_12
    run_mode && lcd_ctrl_nxt.ext |=>
    second_pins.oe[7:4] == 4'hf &&
    second_pins.o[7:4] == $past(lcd_signal))
    else $error("Extended select not routing LCD signals");

  c_write_then_read: cover property (
    wr && hit_d1 ##1 rd && hit_d1);
  c_enter_standby: cover property (
    mode_r == dgp_pkg::DGP_ACTIVE ##1 mode_r == dgp_pkg::DGP_STANDBY);
  c_ext_select: cover property (lcd_ctrl_r.ext && run_mode);
  c_sleep_resume: cover property (
    mode_r == dgp_pkg::DGP_SLEEP ##1 mode_r == dgp_pkg::DGP_ACTIVE);
  c_sel_split: cover property (
    run_mode && lcd_ctrl_r.sel == 4'h2);

  a_second_standby: assert property ( // RULE_10
    mode_r == dgp_pkg::DGP_STANDBY |-> second_pins.oe == 8'h00)
    else $error("Second port drives in standby");

  a_second_holds: assert property ( // RULE_10
    hold_nxt && !$past(rst) |=> $stable(second_pins))
    else $error("Second port changed during a hold mode");

endmodule // dgp_top

// [design/dgp_cfg.svh]
// Offsets, field positions and reset values of the dual port block
`ifndef DGP_CFG_SVH
`define DGP_CFG_SVH

// ********************************
// Register byte addresses
// ********************************
`define DGP_FIRST_DATA_ADDR 16'hffdb
`define DGP_SECOND_DATA_ADDR 16'hffdc
`define DGP_FIRST_DIR_ADDR 16'hffeb
`define DGP_SECOND_DIR_ADDR 16'hffec
`define DGP_LCD_CTRL_ADDR 16'hffc0
`define DGP_MODE_ADDR 16'hffc1

// ********************************
// Reset values and read constants
// ********************************
`define DGP_DATA_RESET 8'h00
`define DGP_DIR_RESET 8'h00
`define DGP_LCD_CTRL_RESET 5'h00
`define DGP_DIR_READ 8'hff
`define DGP_UNMAPPED_READ 8'h00

// ********************************
// Field positions in lcd_port_control and the mode register
// ********************************
`define DGP_SEL_LSB 0
`define DGP_SEL_MSB 3
`define DGP_EXT_BIT 4
`define DGP_MODE_LSB 0
`define DGP_MODE_MSB 2

// ********************************
// Segment select codes
// ********************************
`define DGP_SEL_GPIO_HI 3'h0
`define DGP_SEL_GPIO_LO_MAX 4'h2
`define DGP_SEL_GPIO_SECOND 4'h0

`endif

// [design/dgp_pkg.sv]
// Types shared by the dual port block
package dgp_pkg;

  // ********************************
  // Operating modes, Gray along the usual path
  // ********************************
  typedef enum logic [2:0] {
    DGP_ACTIVE = 3'h0,
    DGP_SUBACTIVE = 3'h1,
    DGP_SLEEP = 3'h3,
    DGP_SUBSLEEP = 3'h2,
    DGP_WATCH = 3'h6,
    DGP_STANDBY = 3'h7
  } dgp_mode_t;

  // ********************************
  // Pin drive carrier
  // ********************************
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } dgp_drive_t;

  // ********************************
  // Segment control carrier
  // ********************************
  typedef struct packed {
    logic ext;
    logic [3:0] sel;
  } dgp_lcd_ctrl_t;

endpackage

// [design/dgp_port_regs.sv]
// Data latch and write-only direction register of one port
`timescale 1ns/1ps
`include "dgp_cfg.svh"

module dgp_port_regs #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic data_we,
  input wire logic dir_we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] latch_r,
  output logic [WIDTH-1:0] dir_r,
  output logic [WIDTH-1:0] latch_nxt,
  output logic [WIDTH-1:0] dir_nxt
);

  always_comb begin
    latch_nxt = data_we ? wdata : latch_r;
    dir_nxt = dir_we ? wdata : dir_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_r <= WIDTH'(`DGP_DATA_RESET); // RULE_01
    end else begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_r <= WIDTH'(`DGP_DIR_RESET); // RULE_07
    end else begin
      dir_r <= dir_nxt;
    end
  end

endmodule // dgp_port_regs

// [design/dgp_pin_mux.sv]
// Per-pin choice between general I/O, segment and LCD signal drive
`timescale 1ns/1ps
`include "dgp_cfg.svh"

module dgp_pin_mux #(
  parameter bit SECOND = 1'b0
) (
  input dgp_pkg::dgp_lcd_ctrl_t ctrl,
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] lcd_drive_output,
  input wire logic [3:0] lcd_sig,
  output dgp_pkg::dgp_drive_t drive
);

  logic gpio_hi;
  logic gpio_lo;

  always_comb begin
    if (SECOND) begin
      gpio_hi = (ctrl.sel == `DGP_SEL_GPIO_SECOND); // RULE_11
      gpio_lo = (ctrl.sel == `DGP_SEL_GPIO_SECOND); // RULE_11
    end else begin
      gpio_hi = (ctrl.sel[3:1] == `DGP_SEL_GPIO_HI); // RULE_08
      gpio_lo = (ctrl.sel <= `DGP_SEL_GPIO_LO_MAX); // RULE_09
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic gpio;
    logic use_sig;
    assign gpio = (i >= 4) ? gpio_hi : gpio_lo;
    assign use_sig = SECOND && (i >= 4) && ctrl.ext; // RULE_12
    always_comb begin
      if (use_sig) begin
        drive.o[i] = lcd_sig[i % 4];
        drive.oe[i] = 1'b1;
      end else if (gpio) begin
        drive.o[i] = latch[i];
        drive.oe[i] = dir[i]; // RULE_04 RULE_05
      end else begin
        drive.o[i] = lcd_drive_output[i];
        drive.oe[i] = 1'b1;
      end
    end
  end

endmodule // dgp_pin_mux

// [test/dgp_pin_model.sv]
// Far-side model of the port pins: wire level seen by the inputs
`timescale 1ns/1ps

module dgp_pin_model (
  input dgp_pkg::dgp_drive_t first_pins,
  input dgp_pkg::dgp_drive_t second_pins,
  input wire logic [7:0] first_ext,
  input wire logic [7:0] second_ext,
  output logic [7:0] first_pin_in,
  output logic [7:0] second_pin_in
);
  // ********************************
  // Wire resolution
  // ********************************
  // Device drive wins, else the external source sets the level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      first_pin_in[i] = first_pins.oe[i] ? first_pins.o[i] : first_ext[i];
      second_pin_in[i] = second_pins.oe[i] ? second_pins.o[i] : second_ext[i];
    end
  end
endmodule // dgp_pin_model

// [test/dgp_top_tb.sv]
// Self-checking testbench of the dual port block
`timescale 1ns/1ps
`include "dgp_cfg.svh"

module dgp_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] first_pin_in;
  logic [7:0] second_pin_in;
  dgp_pkg::dgp_drive_t first_pins;
  dgp_pkg::dgp_drive_t second_pins;
  logic [7:0] lcd_drive_first = 8'h3c;
  logic [7:0] lcd_drive_second = 8'hc3;
  logic [3:0] lcd_signal = 4'h9;
  logic [7:0] first_ext = 8'h3c;
  logic [7:0] second_ext = 8'hc3;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  dgp_top dut_u (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .first_pin_in(first_pin_in), .second_pin_in(second_pin_in),
    .first_pins(first_pins), .second_pins(second_pins),
    .lcd_drive_first(lcd_drive_first), .lcd_drive_second(lcd_drive_second),
    .lcd_signal(lcd_signal)
  );

  dgp_pin_model pins_u (
    .first_pins(first_pins), .second_pins(second_pins),
    .first_ext(first_ext), .second_ext(second_ext),
    .first_pin_in(first_pin_in), .second_pin_in(second_pin_in)
  );

  // ********************************
  // Shared tasks
  // ********************************
  task automatic test_done();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Returns just after the edge that takes the write
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic reset_check();
    rd_chk(`DGP_FIRST_DATA_ADDR, 8'h3c);
    rd_chk(`DGP_SECOND_DATA_ADDR, 8'hc3);
    chk({8'h00, first_pins.oe}, 16'h0000);
    chk({8'h00, second_pins.oe}, 16'h0000);
    rd_chk(`DGP_FIRST_DIR_ADDR, 8'hff);
    rd_chk(`DGP_SECOND_DIR_ADDR, 8'hff);
    rd_chk(`DGP_LCD_CTRL_ADDR, 8'h00);
    rd_chk(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_ACTIVE});
    rd_chk(16'hffd0, 8'h00);
    @(posedge core_clk);
    #1;
    chk({8'h00, rdata}, 16'h0000);
    wr_reg(`DGP_FIRST_DIR_ADDR, 8'hff);
    wr_reg(`DGP_SECOND_DIR_ADDR, 8'hff);
    chk(first_pins, 16'h00ff);
    chk(second_pins, 16'h00ff);
    rd_chk(`DGP_FIRST_DATA_ADDR, 8'h00);
    rd_chk(`DGP_SECOND_DATA_ADDR, 8'h00);
  endtask

  task automatic io_check();
    wr_reg(`DGP_FIRST_DATA_ADDR, 8'ha5);
    wr_reg(`DGP_FIRST_DIR_ADDR, 8'h0f);
    chk({first_pins.o & first_pins.oe, first_pins.oe}, 16'h050f);
    rd_chk(`DGP_FIRST_DATA_ADDR, 8'h35);
    wr_reg(`DGP_SECOND_DATA_ADDR, 8'h5a);
    wr_reg(`DGP_SECOND_DIR_ADDR, 8'hf0);
    chk({second_pins.o & second_pins.oe, second_pins.oe}, 16'h50f0);
    rd_chk(`DGP_SECOND_DATA_ADDR, 8'h53);
    rd_chk(`DGP_SECOND_DIR_ADDR, 8'hff);
  endtask

  task automatic sel_check();
    logic [7:0] g1;
    logic [7:0] g2;
    wr_reg(`DGP_FIRST_DIR_ADDR, 8'hff);
    wr_reg(`DGP_SECOND_DIR_ADDR, 8'hff);
    for (int s = 0; s < 16; s++) begin
      wr_reg(`DGP_LCD_CTRL_ADDR, {4'h0, s[3:0]});
      g1[7:4] = {4{s[3:1] == 3'h0}};
      g1[3:0] = {4{s[3:1] == 3'h0 || s == 2}};
      g2 = {8{s == 0}};
      chk(first_pins, {(g1 & 8'ha5) | (~g1 & 8'h3c), 8'hff});
      chk(second_pins, {(g2 & 8'h5a) | (~g2 & 8'hc3), 8'hff});
    end
    wr_reg(`DGP_LCD_CTRL_ADDR, 8'h10);
    chk(second_pins, 16'h9aff);
    wr_reg(`DGP_LCD_CTRL_ADDR, 8'h13);
    chk(second_pins, 16'h93ff);
    rd_chk(`DGP_LCD_CTRL_ADDR, 8'h13);
    wr_reg(`DGP_LCD_CTRL_ADDR, 8'h00);
  endtask

  task automatic mode_check();
    dgp_pkg::dgp_mode_t hold[3];
    logic [7:0] v;
    hold = '{dgp_pkg::DGP_SLEEP, dgp_pkg::DGP_SUBSLEEP, dgp_pkg::DGP_WATCH};
    v = 8'ha5;
    for (int i = 0; i < 3; i++) begin
      wr_reg(`DGP_MODE_ADDR, {5'h00, hold[i]});
      wr_reg(`DGP_FIRST_DATA_ADDR, ~v);
      chk(first_pins, {v, 8'hff});
      v = ~v;
      wr_reg(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_ACTIVE});
      chk(first_pins, {v, 8'hff});
    end
    wr_reg(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_STANDBY});
    chk({8'h00, first_pins.oe}, 16'h0000);
    chk({8'h00, second_pins.oe}, 16'h0000);
    rd_chk(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_STANDBY});
    wr_reg(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_SUBACTIVE});
    wr_reg(`DGP_FIRST_DATA_ADDR, 8'h33);
    chk(first_pins, 16'h33ff);
    wr_reg(`DGP_MODE_ADDR, 8'h05);
    rd_chk(`DGP_MODE_ADDR, {5'h00, dgp_pkg::DGP_ACTIVE});
  endtask

  // ********************************
  // Main sequence and timeout
  // ********************************
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    chk(first_pins, 16'h0000);
    chk(second_pins, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b0;
    reset_check();
    io_check();
    sel_check();
    mode_check();
    // Reset in mid-run with pins driving
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(first_pins, 16'h0000);
    chk(second_pins, 16'h0000);
    @(posedge core_clk);
    rst <= 1'b0;
    reset_check();
    test_done();
  end
endmodule // dgp_top_tb
